/* rtl/relay_force_pkg.sv */
// Purpose: Shared constants and types for the relay and digital output block
// Assumes: APB register access, 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package relay_force_pkg;

  localparam int ADDR_W = 8;
  localparam int NUM_CHAN = 5;
  localparam int SRC_W = 8;

  // Register byte offsets
  localparam logic [7:0] FORCE_EN_OFS = 8'h00;
  localparam logic [7:0] FORCED_VAL_OFS = 8'h04;
  localparam logic [7:0] SRC_BASE_OFS = 8'h08;
  localparam logic [7:0] SRC_STRIDE = 8'h04;
  localparam logic [7:0] OUT_STATUS_OFS = 8'h1c;

  // Force word layout
  localparam logic [15:0] FORCE_MASK = 16'h002f;
  localparam logic [15:0] FORCE_RESET = 16'h0000;
  localparam int FORCE_POS [NUM_CHAN] = '{0, 1, 2, 3, 5};
  localparam int DIGITAL_CHAN = 4;

  // Source selector codes
  localparam logic [SRC_W-1:0] SRC_OFF = 8'h00;
  localparam logic [SRC_W-1:0] SRC_ON = 8'h01;
  localparam logic [SRC_W-1:0] SRC_READY_RUN = 8'h02;
  localparam logic [SRC_W-1:0] SRC_ENABLED = 8'h04;
  localparam logic [SRC_W-1:0] SRC_PUMP_FIRST = 8'h2e;
  localparam logic [SRC_W-1:0] SRC_PUMP_LAST = 8'h32;
  localparam logic [SRC_W-1:0] SRC_EVENT_ANY = 8'h35;
  localparam logic [SRC_W-1:0] SRC_RUN_PERMIT = 8'h37;
  localparam logic [SRC_W-1:0] SRC_INTERLOCK1 = 8'h38;
  localparam logic [SRC_W-1:0] SRC_RESET = 8'h00;

  // Status bit positions
  localparam int READY_RUN_BIT = 1;
  localparam int ENABLED_BIT = 0;
  localparam int PUMP_FIRST_BIT = 1;
  localparam int RUN_PERMIT_BIT = 7;
  localparam int INTERLOCK1_BIT = 8;

  typedef struct packed {
    logic [15:0] main_word;
    logic [15:0] drive_word1;
    logic [15:0] pump_stage_status;
    logic [15:0] event_word1;
    logic [15:0] hand_off_auto;
  } status_words_type;

endpackage

/* rtl/relay_source_select.sv */
// Purpose: Maps one source selection code to an output level
// Assumes: Status words come from logic on the same clock
// Notes: Purely combinational
`timescale 1ns/1ps
module relay_source_select (
  input wire logic [relay_force_pkg::SRC_W-1:0] code,
  input wire relay_force_pkg::status_words_type status,
  output logic level
);

  logic [relay_force_pkg::SRC_W-1:0] pump_idx;
  logic pump_hit;

  assign pump_hit = (code >= relay_force_pkg::SRC_PUMP_FIRST)
                  && (code <= relay_force_pkg::SRC_PUMP_LAST);
  assign pump_idx = code - relay_force_pkg::SRC_PUMP_FIRST
                  + relay_force_pkg::SRC_W'(relay_force_pkg::PUMP_FIRST_BIT);

  always_comb
  begin
    level = 1'b0;
    if (pump_hit)
    begin
      level = status.pump_stage_status[pump_idx[3:0]];
    end
    else
    begin
      case (code)
        relay_force_pkg::SRC_OFF: level = 1'b0;
        relay_force_pkg::SRC_ON: level = 1'b1;
        relay_force_pkg::SRC_READY_RUN:
          level = status.main_word[relay_force_pkg::READY_RUN_BIT];
        relay_force_pkg::SRC_ENABLED:
          level = status.drive_word1[relay_force_pkg::ENABLED_BIT];
        relay_force_pkg::SRC_EVENT_ANY: level = |status.event_word1;
        relay_force_pkg::SRC_RUN_PERMIT:
          level = status.hand_off_auto[relay_force_pkg::RUN_PERMIT_BIT];
        relay_force_pkg::SRC_INTERLOCK1:
          level = status.hand_off_auto[relay_force_pkg::INTERLOCK1_BIT];
        default: level = 1'b0;
      endcase
    end
  end

endmodule

/* rtl/relay_output_force_select.sv */
// Purpose: Relay and digital output source selection with software force
// Assumes: APB slave, single clock, synchronous active-high reset
// Notes: One access cycle per transfer, pready from a flip-flop
//
// Overview of operation
// - Force bit 0 drives relay four
// - Force bits 1-3 drive relays five-seven
// - Force bit 5 drives digital output
// - Forced data ignored unless force enabled
// - Forced data bit 5 is digital level
// - Forced data word resets to zero
// - Codes 0 and 1 give off, on
// - Relay four selector resets to off
// - Code 2 selects main status bit 1
// - Code 4 selects drive status bit 0
// - Codes 46-50 select pump stage bits 1-5
// - Code 53 is OR of event word
// - Code 55 selects hand-off-auto bit 7
// - Code 56 selects hand-off-auto bit 8
// - Reset clears both force words
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
module relay_output_force_select #(
  parameter int ADDR_W = relay_force_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire relay_force_pkg::status_words_type status,
  output logic relay_output_four,
  output logic relay_output_five,
  output logic relay_output_six,
  output logic relay_output_seven,
  output logic digital_output_one
);

  localparam int NCH = relay_force_pkg::NUM_CHAN;

  if (ADDR_W < 5 || ADDR_W > 8)
  begin : g_check
    $error("ADDR_W must be 5 to 8");
  end

  logic [15:0] force_en_q;
  logic [15:0] force_en_d;
  logic [15:0] forced_q;
  logic [15:0] forced_d;
  logic [relay_force_pkg::SRC_W-1:0] src_q [NCH];
  logic [NCH-1:0] out_q;
  logic [NCH-1:0] out_d;
  logic [NCH-1:0] sel_level;
  logic [NCH-1:0] src_hit;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic pslverr_d;

  wire [7:0] addr8 = 8'(paddr);
  wire setup_phase = psel && !penable;
  wire wr_commit = psel && penable && pwrite && pready_q;
  wire hit_force_en = (addr8 == relay_force_pkg::FORCE_EN_OFS);
  wire hit_forced = (addr8 == relay_force_pkg::FORCED_VAL_OFS);
  wire hit_status = (addr8 == relay_force_pkg::OUT_STATUS_OFS);
  wire any_hit = hit_force_en || hit_forced || hit_status || (|src_hit);

  // Reserved bits are never stored
  assign force_en_d = (wr_commit && hit_force_en)
                    ? (pwdata[15:0] & relay_force_pkg::FORCE_MASK) : force_en_q;
  assign forced_d = (wr_commit && hit_forced)
                  ? (pwdata[15:0] & relay_force_pkg::FORCE_MASK) : forced_q;

  // Per-channel selection and forcing
  for (genvar i = 0; i < NCH; i++)
  begin : g_chan
    localparam int FP = relay_force_pkg::FORCE_POS[i];
    localparam logic [7:0] SRC_OFS = relay_force_pkg::SRC_BASE_OFS
                                   + 8'(i) * relay_force_pkg::SRC_STRIDE;
    assign src_hit[i] = (addr8 == SRC_OFS);

    relay_source_select u_sel (
      .code(src_q[i]),
      .status(status),
      .level(sel_level[i])
    );

    // Force overrides the multiplexer output
    assign out_d[i] = force_en_q[FP] ? forced_q[FP] : sel_level[i];

    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        src_q[i] <= relay_force_pkg::SRC_RESET;
      end
      else if (wr_commit && src_hit[i])
      begin
        src_q[i] <= pwdata[relay_force_pkg::SRC_W-1:0];
      end
    end
  end

  // Read data mux
  always_comb
  begin
    prdata_d = 32'h0000_0000;
    for (int k = 0; k < NCH; k++)
    begin
      if (src_hit[k])
      begin
        prdata_d = 32'(src_q[k]);
      end
    end
    if (hit_force_en)
    begin
      prdata_d = 32'(force_en_q);
    end
    if (hit_forced)
    begin
      prdata_d = 32'(forced_q);
    end
    if (hit_status)
    begin
      prdata_d = 32'(out_q);
    end
  end

  assign pslverr_d = !any_hit;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      force_en_q <= relay_force_pkg::FORCE_RESET;
      forced_q <= relay_force_pkg::FORCE_RESET;
      out_q <= '0;
    end
    else
    begin
      force_en_q <= force_en_d;
      forced_q <= forced_d;
      out_q <= out_d;
    end
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup_phase;
      pslverr_q <= setup_phase && pslverr_d;
      if (setup_phase && !pwrite)
      begin
        prdata_q <= prdata_d;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign relay_output_four = out_q[0];
  assign relay_output_five = out_q[1];
  assign relay_output_six = out_q[2];
  assign relay_output_seven = out_q[3];
  assign digital_output_one = out_q[relay_force_pkg::DIGITAL_CHAN];

  // Checks
  sequence s_wr_force_en;
    psel && penable && pwrite && pready_q && hit_force_en;
  endsequence

  sequence s_setup_then_ready;
    setup_phase ##1 (pready_q && penable);
  endsequence

  property p_force_four;
    @(posedge clk) disable iff (sys_rst)
    force_en_q[0] |=> (relay_output_four == $past(forced_q[0]));
  endproperty
  a_force_four: assert property (p_force_four)
    else $error("relay four not forced");

  property p_force_seven;
    @(posedge clk) disable iff (sys_rst)
    force_en_q[3] |=> (relay_output_seven == $past(forced_q[3]));
  endproperty
  a_force_seven: assert property (p_force_seven)
    else $error("relay seven not forced");

  property p_force_digital;
    @(posedge clk) disable iff (sys_rst)
    force_en_q[5] |=> (digital_output_one == $past(forced_q[5]));
  endproperty
  a_force_digital: assert property (p_force_digital)
    else $error("digital output not forced");

  property p_no_force;
    @(posedge clk) disable iff (sys_rst)
    !force_en_q[1] |=> (relay_output_five == $past(sel_level[1]));
  endproperty
  a_no_force: assert property (p_no_force)
    else $error("relay five ignored its source");

  property p_reset_clear;
    @(posedge clk)
    sys_rst |=> (forced_q == 16'h0000 && force_en_q == 16'h0000
                 && src_q[0] == relay_force_pkg::SRC_OFF);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left force or source state");

  property p_code_off_on;
    @(posedge clk) disable iff (sys_rst)
    (!force_en_q[0] && src_q[0] <= relay_force_pkg::SRC_ON)
      |=> (relay_output_four == $past(src_q[0][0]));
  endproperty
  a_code_off_on: assert property (p_code_off_on)
    else $error("constant source wrong");

  property p_ready_run;
    @(posedge clk) disable iff (sys_rst)
    (!force_en_q[0] && src_q[0] == relay_force_pkg::SRC_READY_RUN)
      |=> (relay_output_four == $past(status.main_word[1]));
  endproperty
  a_ready_run: assert property (p_ready_run)
    else $error("ready source wrong");

  property p_event_any;
    @(posedge clk) disable iff (sys_rst)
    (!force_en_q[0] && src_q[0] == relay_force_pkg::SRC_EVENT_ANY)
      |=> (relay_output_four == $past(|status.event_word1));
  endproperty
  a_event_any: assert property (p_event_any)
    else $error("event source wrong");

  property p_interlock;
    @(posedge clk) disable iff (sys_rst)
    (!force_en_q[0] && src_q[0] == relay_force_pkg::SRC_INTERLOCK1)
      |=> (relay_output_four == $past(status.hand_off_auto[8]));
  endproperty
  a_interlock: assert property (p_interlock)
    else $error("interlock source wrong");

  property p_reserved_bits;
    @(posedge clk) disable iff (sys_rst)
    s_wr_force_en |=> ((force_en_q & ~relay_force_pkg::FORCE_MASK) == 16'h0000
                       && force_en_q == ($past(pwdata[15:0]) & relay_force_pkg::FORCE_MASK));
  endproperty
  a_reserved_bits: assert property (p_reserved_bits)
    else $error("force enable write wrong");

  property p_apb_ready;
    @(posedge clk) disable iff (sys_rst)
    setup_phase |-> s_setup_then_ready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("pready not in first access cycle");

endmodule

/* testbench/relay_driver_model.sv */
// Purpose: Behavioural model of the relay and digital output drivers
// Assumes: Outputs are levels on the system clock
// Notes: Collects the five driven levels into one vector
`timescale 1ns/1ps
module relay_driver_model (
  input wire logic relay_output_four,
  input wire logic relay_output_five,
  input wire logic relay_output_six,
  input wire logic relay_output_seven,
  input wire logic digital_output_one,
  output logic [4:0] coil_state
);
  // Bit 4 digital output, bits 3-0 relays seven..four
  assign coil_state = {digital_output_one, relay_output_seven, relay_output_six,
    relay_output_five, relay_output_four};
endmodule

/* testbench/relay_output_force_select_test.sv */
// Purpose: Self-checking bench for the relay output force block
// Assumes: APB slave answers in its own time, waits are bounded
// Notes: Source code checks use relay four
`timescale 1ns/1ps
module relay_output_force_select_test;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  relay_force_pkg::status_words_type status;
  logic ro4, ro5, ro6, ro7, do1;
  logic [4:0] outs;
  int fails = 0;
  int n_tests = 0;

  relay_output_force_select #(.ADDR_W(8)) i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .status(status), .relay_output_four(ro4),
    .relay_output_five(ro5), .relay_output_six(ro6), .relay_output_seven(ro7),
    .digital_output_one(do1));
  relay_driver_model i_drv (.relay_output_four(ro4), .relay_output_five(ro5),
    .relay_output_six(ro6), .relay_output_seven(ro7), .digital_output_one(do1),
    .coil_state(outs));

  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  task conclude;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #100000;
    fails++;
    conclude;
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task settle;
    repeat (3) @(posedge clk);
  endtask

  function automatic relay_force_pkg::status_words_type hot(input int w, input int b);
    relay_force_pkg::status_words_type s;
    s = '0;
    s[(4 - w) * 16 + b] = 1'b1;
    return s;
  endfunction

  task try_code(input logic [7:0] c, input relay_force_pkg::status_words_type s,
    input logic e);
    wr(8'h08, {24'h0, c});
    status <= s;
    settle;
    chk("relay_output_four", {31'h0, e}, {31'h0, ro4});
  endtask

  task pair(input logic [7:0] c, input int w, input int b);
    try_code(c, hot(w, b), 1'b1);
    try_code(c, ~hot(w, b), 1'b0);
  endtask

  task t_reset;
    rdchk("force_enable", 8'h00, 32'h0);
    rdchk("forced_values", 8'h04, 32'h0);
    rdchk("source_four", 8'h08, 32'h0);
    chk("outputs", 32'h0, {27'h0, outs});
  endtask

  // Each source register energizes only its own output
  task t_chan;
    for (int k = 0; k < 5; k++)
    begin
      wr(8'h08 + 8'(4 * k), 32'h1);
      chk("source_slverr", 32'h0, {31'h0, er});
      settle;
      chk("outputs", 32'h1 << k, {27'h0, outs});
      rdchk("source_code", 8'h08 + 8'(4 * k), 32'h1);
      wr(8'h08 + 8'(4 * k), 32'h0);
      settle;
      chk("outputs", 32'h0, {27'h0, outs});
    end
  endtask

  task t_codes;
    try_code(8'h00, '1, 1'b0);
    try_code(8'h01, '0, 1'b1);
    pair(8'h02, 0, 1);
    pair(8'h04, 1, 0);
    for (int i = 0; i < 5; i++)
      pair(8'h2e + i[7:0], 2, i + 1);
    try_code(8'h35, hot(3, 15), 1'b1);
    try_code(8'h35, '0, 1'b0);
    pair(8'h37, 4, 7);
    pair(8'h38, 4, 8);
    try_code(8'h03, '1, 1'b0);
    try_code(8'h33, '1, 1'b0);
    try_code(8'h34, '1, 1'b0);
    try_code(8'h36, '1, 1'b0);
    try_code(8'h00, '1, 1'b0);
  endtask

  task t_force;
    wr(8'h04, 32'hffff);
    rdchk("forced_mask", 8'h04, 32'h2f);
    settle;
    chk("outputs", 32'h0, {27'h0, outs});
    wr(8'h00, 32'hffff);
    rdchk("enable_mask", 8'h00, 32'h2f);
    settle;
    chk("outputs", 32'h1f, {27'h0, outs});
    wr(8'h04, 32'h0025);
    settle;
    chk("outputs", 32'h15, {27'h0, outs});
    wr(8'h00, 32'h0010);
    wr(8'h04, 32'h002f);
    settle;
    chk("outputs", 32'h0, {27'h0, outs});
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h0);
    settle;
    chk("outputs", 32'h0, {27'h0, outs});
    wr(8'h00, 32'h0);
    settle;
    chk("outputs", 32'h1, {27'h0, outs});
    rdchk("output_status", 8'h1c, 32'h1);
  endtask

  task t_bus;
    apb(1'b0, 8'hfc, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
    wr(8'h1c, 32'h1f);
    chk("slverr_ro", 32'h0, {31'h0, er});
  endtask

  task t_rerst;
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h1);
    @(posedge clk);
    sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    rdchk("force_enable", 8'h00, 32'h0);
    rdchk("forced_values", 8'h04, 32'h0);
    chk("outputs", 32'h0, {27'h0, outs});
  endtask

  initial
  begin
    sys_rst = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    status = '0;
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    t_reset;
    t_chan;
    t_codes;
    t_force;
    t_bus;
    t_rerst;
    conclude;
  end
endmodule
